// *** vdvs_core.sv ***
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "vdvs_defines.svh"

// Behaviour
// - Field 1 sync rises at start point
// - Field 1 sync falls at stop point
// - Field 2 sync rises at start point
// - Field 2 sync falls at stop point
// - Reloads only when external sync enabled
// - External vertical sync loads line counter
// - External horizontal sync loads clock counter
// - External horizontal sync loads pixel counter
// - Video modes: count luma/blue/red request sets
// - Raw mode: luma requests only
// - Reserved bits read zero, ignore writes
module vdvs_core (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Avalon-MM slave.
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // External sync pins.
  input  wire logic        i_ext_hsync,
  input  wire logic        i_ext_vsync,
  // Pixel rate and DMA request strobe from the datapath.
  input  wire logic        i_pix_en,
  input  wire logic        i_dma_slot,
  // Video outputs.
  output logic             o_vsync,
  output logic             o_field2,
  output vdvs_pkg::vdvs_dma_t o_dma_req,
  output logic [3:0]       o_video_clock_counter,
  // Interrupt.
  output logic             o_irq
);

  // Registers.
  logic [31:0] f1_start_ff;
  logic [31:0] f1_stop_ff;
  logic [31:0] f2_start_ff;
  logic [31:0] f2_stop_ff;
  logic [31:0] reload_ff;
  logic [31:0] evt_count_ff;
  logic [31:0] ctrl_ff;
  logic [`VDVS_IRQ_W-1:0] int_stat_ff;
  logic [`VDVS_IRQ_W-1:0] int_en_ff;
  // Counters and state.
  logic [11:0] frame_line_counter_ff;
  logic [11:0] frame_pixel_counter_ff;
  logic [3:0]  video_clock_counter_ff;
  logic        vsync_ff;
  logic        field2_ff;
  logic [11:0] evt_done_ff;
  vdvs_pkg::vdvs_dma_t dma_ff;
  logic        ack_ff;
  // Combinational helpers.
  logic [31:0] wmask;
  logic [31:0] nxt_rdata;
  logic        wr_stb;
  logic        rd_stb;
  logic        ext_h_rise;
  logic        ext_v_rise;
  logic        ext_h_load;
  logic        ext_v_load;
  logic        hit_f1_on;
  logic        hit_f1_off;
  logic        hit_f2_on;
  logic        hit_f2_off;
  logic        vs_on;
  logic        vs_off;
  logic        line_end;
  logic        field_end;
  logic        evt_fire;
  logic [11:0] line_len;
  logic [11:0] evt_target;
  logic [`VDVS_IRQ_W-1:0] irq_evt;
  logic        enable;
  vdvs_pkg::vdvs_mode_t mode;
  vdvs_pkg::vdvs_point_t cnt;
  // Programmed compare points with the reserved bits dropped.
  vdvs_pkg::vdvs_point_t pt_f1_on;
  vdvs_pkg::vdvs_point_t pt_f1_off;
  vdvs_pkg::vdvs_point_t pt_f2_on;
  vdvs_pkg::vdvs_point_t pt_f2_off;

  // Control fields and the counter pair seen by the comparators.
  assign enable   = ctrl_ff[`VDVS_CTL_EN];
  assign mode     = vdvs_pkg::vdvs_mode_t'(
                      ctrl_ff[`VDVS_CTL_MODE_MSB:`VDVS_CTL_MODE_LSB]);
  assign line_len = ctrl_ff[`VDVS_CTL_LEN_MSB:`VDVS_CTL_LEN_LSB];
  assign cnt      = '{line: frame_line_counter_ff,
                      pixel: frame_pixel_counter_ff};

  // Byte enables turn into a bit mask for writes.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{i_avs_byteenable[i]}};
    end
  end

  // Every access is answered one cycle after it is presented.
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
  assign wr_stb = i_avs_write & ack_ff;
  assign rd_stb = i_avs_read & ~ack_ff;

  // The acknowledge flag marks the second cycle of an access.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (i_avs_read | i_avs_write) & ~ack_ff;
    end
  end

  // Software-programmed registers; reserved bits never store.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      f1_start_ff  <= `VDVS_RST_WORD;
      f1_stop_ff   <= `VDVS_RST_WORD;
      f2_start_ff  <= `VDVS_RST_WORD;
      f2_stop_ff   <= `VDVS_RST_WORD;
      reload_ff    <= `VDVS_RST_WORD;
      evt_count_ff <= `VDVS_RST_WORD;
      ctrl_ff      <= `VDVS_RST_WORD | {4'h0, `VDVS_RST_LINE_LEN, 16'h0000};
      int_en_ff    <= '0;
    end else if (wr_stb) begin
      unique case (i_avs_address)
        `VDVS_OFS_F1_START: f1_start_ff <= (f1_start_ff & ~(wmask &
                `VDVS_PT_MASK)) | (i_avs_writedata & wmask & `VDVS_PT_MASK);
        `VDVS_OFS_F1_STOP: f1_stop_ff <= (f1_stop_ff & ~(wmask &
                `VDVS_PT_MASK)) | (i_avs_writedata & wmask & `VDVS_PT_MASK);
        `VDVS_OFS_F2_START: f2_start_ff <= (f2_start_ff & ~(wmask &
                `VDVS_PT_MASK)) | (i_avs_writedata & wmask & `VDVS_PT_MASK);
        `VDVS_OFS_F2_STOP: f2_stop_ff <= (f2_stop_ff & ~(wmask &
                `VDVS_PT_MASK)) | (i_avs_writedata & wmask & `VDVS_PT_MASK);
        `VDVS_OFS_RELOAD: reload_ff <= (reload_ff & ~(wmask &
                `VDVS_RLD_MASK)) | (i_avs_writedata & wmask & `VDVS_RLD_MASK);
        `VDVS_OFS_EVT_COUNT: evt_count_ff <= (evt_count_ff & ~(wmask &
                `VDVS_PT_MASK)) | (i_avs_writedata & wmask & `VDVS_PT_MASK);
        `VDVS_OFS_CTRL: ctrl_ff <= (ctrl_ff & ~(wmask &
                `VDVS_CTL_MASK)) | (i_avs_writedata & wmask & `VDVS_CTL_MASK);
        `VDVS_OFS_INT_EN: if (i_avs_byteenable[0]) begin
          int_en_ff <= i_avs_writedata[`VDVS_IRQ_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses and reserved bits return zero.
  always_comb begin
    nxt_rdata = '0;
    unique case (i_avs_address)
      `VDVS_OFS_F1_START:  nxt_rdata = f1_start_ff;
      `VDVS_OFS_F1_STOP:   nxt_rdata = f1_stop_ff;
      `VDVS_OFS_F2_START:  nxt_rdata = f2_start_ff;
      `VDVS_OFS_F2_STOP:   nxt_rdata = f2_stop_ff;
      `VDVS_OFS_RELOAD:    nxt_rdata = reload_ff;
      `VDVS_OFS_EVT_COUNT: nxt_rdata = evt_count_ff;
      `VDVS_OFS_CTRL:      nxt_rdata = ctrl_ff;
      `VDVS_OFS_STATUS:    nxt_rdata = {4'h0, frame_line_counter_ff,
                                        video_clock_counter_ff,
                                        frame_pixel_counter_ff};
      `VDVS_OFS_INT_STAT:  nxt_rdata = {28'h0000000, int_stat_ff};
      `VDVS_OFS_INT_EN:    nxt_rdata = {28'h0000000, int_en_ff};
      default:             nxt_rdata = '0;
    endcase
  end

  // Read data is registered and valid when waitrequest drops.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_avs_readdata <= '0;
    end else if (rd_stb) begin
      o_avs_readdata <= nxt_rdata;
    end
  end

  // External sync pins are synchronised before use.
  vdvs_sync_in u_sync_h (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_ext_hsync),
    .o_rise  (ext_h_rise)
  );

  vdvs_sync_in u_sync_v (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_ext_vsync),
    .o_rise  (ext_v_rise)
  );

  // Reloads apply only when the matching external sync is selected.
  assign ext_h_load = enable & ctrl_ff[`VDVS_CTL_EXT_H] & ext_h_rise;
  assign ext_v_load = enable & ctrl_ff[`VDVS_CTL_EXT_V] & ext_v_rise;

  // A pixel reload beyond the line length wraps at the next pixel.
  // The stop point of the current field closes that field.
  assign line_end  = (frame_pixel_counter_ff >= line_len);
  assign field_end = vs_off;

  // Pixel and clock counters: reload on external hsync, else advance.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      frame_pixel_counter_ff <= `VDVS_CNT_ZERO;
      video_clock_counter_ff <= `VDVS_VC_ZERO;
    end else if (ext_h_load) begin
      frame_pixel_counter_ff <= reload_ff[`VDVS_LO_MSB:`VDVS_LO_LSB];
      video_clock_counter_ff <= reload_ff[`VDVS_CLK_MSB:`VDVS_CLK_LSB];
    end else if (enable && i_pix_en) begin
      video_clock_counter_ff <= video_clock_counter_ff + `VDVS_VC_ONE;
      frame_pixel_counter_ff <= line_end ? `VDVS_CNT_ZERO
                            : frame_pixel_counter_ff + `VDVS_CNT_ONE;
    end
  end

  // Line counter: reload on external vsync, else step at line wrap.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      frame_line_counter_ff <= `VDVS_CNT_ZERO;
    end else if (ext_v_load) begin
      frame_line_counter_ff <= reload_ff[`VDVS_HI_MSB:`VDVS_HI_LSB];
    end else if (enable && i_pix_en && line_end) begin
      frame_line_counter_ff <= frame_line_counter_ff + `VDVS_CNT_ONE;
    end
  end

  // Line and pixel fields of each point register.
  assign pt_f1_on  = '{line: f1_start_ff[`VDVS_HI_MSB:`VDVS_HI_LSB],
                       pixel: f1_start_ff[`VDVS_LO_MSB:`VDVS_LO_LSB]};
  assign pt_f1_off = '{line: f1_stop_ff[`VDVS_HI_MSB:`VDVS_HI_LSB],
                       pixel: f1_stop_ff[`VDVS_LO_MSB:`VDVS_LO_LSB]};
  assign pt_f2_on  = '{line: f2_start_ff[`VDVS_HI_MSB:`VDVS_HI_LSB],
                       pixel: f2_start_ff[`VDVS_LO_MSB:`VDVS_LO_LSB]};
  assign pt_f2_off = '{line: f2_stop_ff[`VDVS_HI_MSB:`VDVS_HI_LSB],
                       pixel: f2_stop_ff[`VDVS_LO_MSB:`VDVS_LO_LSB]};

  // Compare points for both fields.
  vdvs_point_match u_f1_on (
    .i_cnt (cnt),
    .i_pt  (pt_f1_on),
    .o_hit (hit_f1_on)
  );

  vdvs_point_match u_f1_off (
    .i_cnt (cnt),
    .i_pt  (pt_f1_off),
    .o_hit (hit_f1_off)
  );

  vdvs_point_match u_f2_on (
    .i_cnt (cnt),
    .i_pt  (pt_f2_on),
    .o_hit (hit_f2_on)
  );

  vdvs_point_match u_f2_off (
    .i_cnt (cnt),
    .i_pt  (pt_f2_off),
    .o_hit (hit_f2_off)
  );

  // Sync edges come from the points of the current field only.
  assign vs_on  = enable & (field2_ff ? hit_f2_on : hit_f1_on);
  assign vs_off = enable & (field2_ff ? hit_f2_off : hit_f1_off);

  // Vertical sync level; the stop point ends the field's sync and field.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      vsync_ff  <= 1'b0;
      field2_ff <= 1'b0;
    end else if (!enable) begin
      vsync_ff  <= 1'b0;
      field2_ff <= 1'b0;
    end else if (vs_off) begin
      vsync_ff  <= 1'b0;
      field2_ff <= ~field2_ff;
    end else if (vs_on) begin
      vsync_ff  <= 1'b1;
    end
  end

  // Per-field DMA request budget.
  assign evt_target = field2_ff ? evt_count_ff[`VDVS_HI_MSB:`VDVS_HI_LSB]
                                : evt_count_ff[`VDVS_LO_MSB:`VDVS_LO_LSB];
  assign evt_fire   = enable & i_dma_slot & (evt_done_ff < evt_target);

  // Requests issued so far in this field; cleared at the field end.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      evt_done_ff <= `VDVS_CNT_ZERO;
    end else if (!enable || field_end) begin
      evt_done_ff <= `VDVS_CNT_ZERO;
    end else if (evt_fire) begin
      evt_done_ff <= evt_done_ff + `VDVS_CNT_ONE;
    end
  end

  // Request pulses: full set in video modes, luma only in raw mode.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      dma_ff <= '0;
    end else begin
      dma_ff.luma <= evt_fire;
      dma_ff.blue <= evt_fire && (mode != vdvs_pkg::VDVS_MODE_RAW);
      dma_ff.red  <= evt_fire && (mode != vdvs_pkg::VDVS_MODE_RAW);
    end
  end

  // Sticky interrupt status; a new event wins over a clear.
  assign irq_evt = {evt_fire && (evt_done_ff + `VDVS_CNT_ONE == evt_target),
                    field_end, vs_off, vs_on};

  // Status bits stay set until software writes ones to the clear word.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      int_stat_ff <= '0;
    end else if (wr_stb && i_avs_address == `VDVS_OFS_INT_CLR
                 && i_avs_byteenable[0]) begin
      int_stat_ff <= (int_stat_ff & ~i_avs_writedata[`VDVS_IRQ_W-1:0])
                     | irq_evt;
    end else begin
      int_stat_ff <= int_stat_ff | irq_evt;
    end
  end

  // Outputs.
  assign o_vsync               = vsync_ff;
  assign o_field2              = field2_ff;
  assign o_dma_req             = dma_ff;
  assign o_video_clock_counter = video_clock_counter_ff;
  assign o_irq                 = |(int_stat_ff & int_en_ff);

endmodule

// *** vdvs_defines.svh ***
`ifndef VDVS_DEFINES_SVH
`define VDVS_DEFINES_SVH

// Register byte addresses.
`define VDVS_OFS_F1_START   8'h00
`define VDVS_OFS_F1_STOP    8'h04
`define VDVS_OFS_F2_START   8'h08
`define VDVS_OFS_F2_STOP    8'h0C
`define VDVS_OFS_RELOAD     8'h10
`define VDVS_OFS_EVT_COUNT  8'h14
`define VDVS_OFS_CTRL       8'h18
`define VDVS_OFS_STATUS     8'h1C
`define VDVS_OFS_INT_STAT   8'h20
`define VDVS_OFS_INT_CLR    8'h24
`define VDVS_OFS_INT_EN     8'h28

// Field positions.
`define VDVS_HI_MSB         27
`define VDVS_HI_LSB         16
`define VDVS_CLK_MSB        15
`define VDVS_CLK_LSB        12
`define VDVS_LO_MSB         11
`define VDVS_LO_LSB         0

// Writable bits of a point or count register, and of the reload register.
`define VDVS_PT_MASK        32'h0FFF_0FFF
`define VDVS_RLD_MASK       32'h0FFF_FFFF

// Control register bits.
`define VDVS_CTL_EN         0
`define VDVS_CTL_EXT_H      1
`define VDVS_CTL_EXT_V      2
`define VDVS_CTL_MODE_LSB   3
`define VDVS_CTL_MODE_MSB   4
`define VDVS_CTL_LEN_LSB    16
`define VDVS_CTL_LEN_MSB    27
`define VDVS_CTL_MASK       32'h0FFF_001F

// Interrupt bits.
`define VDVS_IRQ_W          4
`define VDVS_IRQ_VS_ON      0
`define VDVS_IRQ_VS_OFF     1
`define VDVS_IRQ_FIELD      2
`define VDVS_IRQ_EVT_DONE   3

// Reset values and counter steps.
`define VDVS_RST_WORD       32'h0000_0000
`define VDVS_RST_LINE_LEN   12'h359
`define VDVS_CNT_ONE        12'h001
`define VDVS_CNT_ZERO       12'h000
`define VDVS_VC_ONE         4'h1
`define VDVS_VC_ZERO        4'h0

`endif

// *** vdvs_pkg.sv ***
package vdvs_pkg;

  // Output data format.
  typedef enum logic [1:0] {
    VDVS_MODE_BT656 = 2'h0,
    VDVS_MODE_YC    = 2'h1,
    VDVS_MODE_RAW   = 2'h2
  } vdvs_mode_t;

  // One compare point: line and pixel.
  typedef struct packed {
    logic [11:0] line;
    logic [11:0] pixel;
  } vdvs_point_t;

  // One DMA request set.
  typedef struct packed {
    logic luma;
    logic blue;
    logic red;
  } vdvs_dma_t;

endpackage

// *** vdvs_sync_in.sv ***
`timescale 1ns/1ps
`include "vdvs_defines.svh"

// Two-stage synchroniser with a rising-edge pulse on the settled level.
module vdvs_sync_in (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Pin level and its rising edge.
  input  wire logic i_pin,
  output logic      o_rise
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // The first stage is read only by the second stage.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Edge pulse lasts one cycle.
  assign o_rise = sync_ff & ~last_ff;

endmodule

// *** vdvs_point_match.sv ***
`timescale 1ns/1ps
`include "vdvs_defines.svh"

// Compares the frame counters with one programmed point.
module vdvs_point_match (
  // Counters and point.
  input  wire vdvs_pkg::vdvs_point_t i_cnt,
  input  wire vdvs_pkg::vdvs_point_t i_pt,
  // Match flag.
  output logic                       o_hit
);

  // Both the line and the pixel must agree.
  assign o_hit = (i_cnt.line == i_pt.line) && (i_cnt.pixel == i_pt.pixel);

endmodule

// *** vdvs_sync_src.sv ***
`timescale 1ns/1ps

// Far-side sync source: each go request gives a four-cycle high pulse.
module vdvs_sync_src (
  // Clock and requests.
  input  wire logic i_clk,
  input  wire logic i_h_go,
  input  wire logic i_v_go,
  // Sync pins, idle low.
  output logic      o_hsync,
  output logic      o_vsync
);
  logic [2:0] h_ff = 3'h0;
  logic [2:0] v_ff = 3'h0;

  // Count the pulse width down to the idle level.
  always @(posedge i_clk) begin
    h_ff <= i_h_go ? 3'h4 : h_ff - {2'h0, h_ff != 3'h0};
    v_ff <= i_v_go ? 3'h4 : v_ff - {2'h0, v_ff != 3'h0};
  end

  // A pin is high while its count runs.
  assign o_hsync = (h_ff != 3'h0);
  assign o_vsync = (v_ff != 3'h0);
endmodule

// *** vdvs_core_checker.sv ***
`timescale 1ns/1ps
`include "vdvs_defines.svh"

// Watches the core ports for bus, sync and request behaviour.
module vdvs_core_checker (
  // Clock and reset.
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  // Register bus.
  input  wire logic [7:0]          i_avs_address,
  input  wire logic                i_avs_read,
  input  wire logic                i_avs_write,
  input  wire logic [31:0]         i_avs_writedata,
  input  wire logic [31:0]         o_avs_readdata,
  input  wire logic                o_avs_waitrequest,
  // Sync and requests.
  input  wire logic                i_ext_hsync,
  input  wire logic                i_dma_slot,
  input  wire logic                o_vsync,
  input  wire logic                o_field2,
  input  wire vdvs_pkg::vdvs_dma_t o_dma_req,
  input  wire logic [3:0]          o_video_clock_counter
);
  logic [1:0] mode_ff;
  logic       ext_h_ff;
  logic [3:0] rld_clk_ff;
  logic       wr_done;

  // A write lands at the edge where waitrequest is low.
  assign wr_done = i_avs_write && !o_avs_waitrequest;

  // Shadow the mode, the hsync reload enable and the clock reload value.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mode_ff    <= 2'h0;
      ext_h_ff   <= 1'b0;
      rld_clk_ff <= 4'h0;
    end else if (wr_done && i_avs_address == `VDVS_OFS_CTRL) begin
      mode_ff  <= i_avs_writedata[`VDVS_CTL_MODE_MSB:`VDVS_CTL_MODE_LSB];
      ext_h_ff <= i_avs_writedata[`VDVS_CTL_EXT_H];
    end else if (wr_done && i_avs_address == `VDVS_OFS_RELOAD) begin
      rld_clk_ff <= i_avs_writedata[`VDVS_CLK_MSB:`VDVS_CLK_LSB];
    end
  end

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // Steps of a bus access.
  sequence s_req_new;
    (i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write);
  endsequence
  sequence s_rd_done;
    i_avs_read && !o_avs_waitrequest;
  endsequence

  // Bus handshake, reserved bits, requests and sync.
  a_wait_first: assert property (s_req_new |-> o_avs_waitrequest)
    else $error("no wait in first access cycle");
  a_wait_once: assert property ((i_avs_read || i_avs_write)
    && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("more than one wait cycle");
  a_unmapped_zero: assert property (s_rd_done ##0
    (i_avs_address > 8'h28) |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (s_rd_done ##0
    (i_avs_address <= 8'h14) |-> (o_avs_readdata & ((i_avs_address
    == `VDVS_OFS_RELOAD) ? 32'hF000_0000 : 32'hF000_F000)) == 32'h0)
    else $error("reserved bits not zero");
  a_dma_cause: assert property (o_dma_req != 3'h0 |-> $past(i_dma_slot))
    else $error("request without slot");
  a_dma_set: assert property (o_dma_req.blue || o_dma_req.red
    |-> o_dma_req == 3'h7)
    else $error("incomplete request set");
  a_raw_luma: assert property (mode_ff == vdvs_pkg::VDVS_MODE_RAW
    && o_dma_req != 3'h0 |-> o_dma_req == 3'h4)
    else $error("chroma request in raw mode");
  a_field_stop: assert property ($changed(o_field2) |-> $fell(o_vsync))
    else $error("field changed without sync stop");
  a_vclk_reload: assert property ($rose(i_ext_hsync) && ext_h_ff
    |-> ##[2:6] (o_video_clock_counter == rld_clk_ff))
    else $error("clock counter not reloaded");
endmodule

bind vdvs_core vdvs_core_checker u_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_ext_hsync(i_ext_hsync),
  .i_dma_slot(i_dma_slot), .o_vsync(o_vsync), .o_field2(o_field2),
  .o_dma_req(o_dma_req), .o_video_clock_counter(o_video_clock_counter)
);

// *** vdvs_core_tb.sv ***
`timescale 1ns/1ps
`include "vdvs_defines.svh"

module vdvs_core_tb;
  logic                i_clk = 1'b0;
  logic                i_rst_b = 1'b0;
  logic [7:0]          i_avs_address = 8'h00;
  logic                i_avs_read = 1'b0;
  logic                i_avs_write = 1'b0;
  logic [31:0]         i_avs_writedata = 32'h0;
  logic                i_pix_en = 1'b0;
  logic                i_dma_slot = 1'b0;
  logic                h_go = 1'b0;
  logic                v_go = 1'b0;
  logic                i_ext_hsync;
  logic                i_ext_vsync;
  logic [31:0]         o_avs_readdata;
  logic                o_avs_waitrequest;
  logic                o_vsync;
  logic                o_field2;
  logic                o_irq;
  vdvs_pkg::vdvs_dma_t o_dma_req;
  logic [3:0]          o_video_clock_counter;
  logic [31:0]         rd;
  logic [2:0]          exp_pat = 3'h7;
  int                  num_errors = 0;
  int                  checks = 0;
  int                  n_good = 0;
  int                  n_bad = 0;
  int                  n;
  int                  g0;
  int                  b0;

  // Clock at 40 MHz.
  always #12.5 i_clk = ~i_clk;

  // Device under test and its far side.
  vdvs_core uut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_ext_hsync(i_ext_hsync), .i_ext_vsync(i_ext_vsync),
    .i_pix_en(i_pix_en), .i_dma_slot(i_dma_slot), .o_vsync(o_vsync),
    .o_field2(o_field2), .o_dma_req(o_dma_req),
    .o_video_clock_counter(o_video_clock_counter), .o_irq(o_irq));
  vdvs_sync_src u_src (.i_clk(i_clk), .i_h_go(h_go), .i_v_go(v_go),
    .o_hsync(i_ext_hsync), .o_vsync(i_ext_vsync));

  // Tally request pulses against the expected pattern.
  always @(posedge i_clk) begin
    if (o_dma_req === exp_pat)
      n_good <= n_good + 1;
    else if (o_dma_req !== 3'h0)
      n_bad <= n_bad + 1;
  end

  task automatic print_verdict;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic timeout;
    num_errors++;
    print_verdict();
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus access, held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    logic w;
    w = 1'b1;
    @(posedge i_clk);
    i_avs_address   <= a;
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    i_avs_writedata <= d;
    for (int k = 0; k < 20 && w !== 1'b0; k++) begin
      @(negedge i_clk);
      w = o_avs_waitrequest;
      rd = o_avs_readdata;
      @(posedge i_clk);
    end
    if (w !== 1'b0)
      timeout();
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
  endtask

  // Ask the far side for sync pulses, then let them settle.
  task automatic ext(input logic h, input logic v);
    @(posedge i_clk);
    h_go <= h;
    v_go <= v;
    @(posedge i_clk);
    h_go <= 1'b0;
    v_go <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask

  // Count cycles until the sync output reaches a level.
  task automatic wait_vs(input logic v, output int cnt);
    cnt = 0;
    while (o_vsync !== v) begin
      @(posedge i_clk);
      #1;
      cnt++;
      if (cnt > 400)
        timeout();
    end
  endtask

  initial begin
    do_reset();
    // Reset values, writable and reserved bits of the word registers.
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      cmp32(rd, 32'h0);
      bus(1'b1, 8'(4 * i), 32'hFFFF_FFFF);
      bus(1'b0, 8'(4 * i), 32'h0);
      cmp32(rd, (i == 4) ? `VDVS_RLD_MASK : `VDVS_PT_MASK);
    end
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    cmp32(rd, 32'h0);
    // External syncs reload the counters only when enabled.
    bus(1'b1, `VDVS_OFS_RELOAD, 32'h0123_50AB);
    bus(1'b1, `VDVS_OFS_CTRL, 32'h0000_0007);
    ext(1'b1, 1'b1);
    bus(1'b0, `VDVS_OFS_STATUS, 32'h0);
    cmp32(rd & `VDVS_RLD_MASK, 32'h0123_50AB);
    bus(1'b1, `VDVS_OFS_RELOAD, 32'h0000_0000);
    bus(1'b1, `VDVS_OFS_CTRL, 32'h0000_0001);
    ext(1'b1, 1'b1);
    bus(1'b0, `VDVS_OFS_STATUS, 32'h0);
    cmp32(rd & `VDVS_RLD_MASK, 32'h0123_50AB);
    // Both fields on 16-pixel lines with one pixel per cycle.
    do_reset();
    bus(1'b1, `VDVS_OFS_F1_START, 32'h0001_0003);
    bus(1'b1, `VDVS_OFS_F1_STOP, 32'h0002_0005);
    bus(1'b1, `VDVS_OFS_F2_START, 32'h0004_0002);
    bus(1'b1, `VDVS_OFS_F2_STOP, 32'h0005_0009);
    bus(1'b1, `VDVS_OFS_CTRL, 32'h000F_0001);
    @(posedge i_clk);
    i_pix_en <= 1'b1;
    wait_vs(1'b1, n);
    wait_vs(1'b0, n);
    cmp32(n, 32'd18);
    wait_vs(1'b1, n);
    cmp32(n, 32'd29);
    cmp32({31'h0, o_field2}, 32'h1);
    wait_vs(1'b0, n);
    cmp32(n, 32'd23);
    @(posedge i_clk);
    i_pix_en <= 1'b0;
    repeat (3) @(posedge i_clk);
    cmp32({31'h0, o_field2}, 32'h0);
    // Sticky status, enable and clear of the interrupt.
    cmp32({31'h0, o_irq}, 32'h0);
    bus(1'b1, `VDVS_OFS_INT_EN, 32'h0000_0001);
    bus(1'b0, `VDVS_OFS_INT_STAT, 32'h0);
    cmp32(rd & 32'h7, 32'h7);
    cmp32({31'h0, o_irq}, 32'h1);
    bus(1'b1, `VDVS_OFS_INT_CLR, 32'h0000_000F);
    bus(1'b0, `VDVS_OFS_INT_STAT, 32'h0);
    cmp32(rd, 32'h0);
    cmp32({31'h0, o_irq}, 32'h0);
    // Field 1 request budget in each output mode.
    for (int m = 0; m < 3; m++) begin
      do_reset();
      bus(1'b1, `VDVS_OFS_EVT_COUNT, 32'h0002_0003);
      bus(1'b1, `VDVS_OFS_F1_STOP, 32'h0001_0001);
      bus(1'b1, `VDVS_OFS_CTRL, (32'(m) << 3) | 32'h0000_0001);
      exp_pat = (m == 2) ? 3'h4 : 3'h7;
      g0 = n_good;
      b0 = n_bad;
      repeat (5) begin
        @(posedge i_clk);
        i_dma_slot <= 1'b1;
        @(posedge i_clk);
        i_dma_slot <= 1'b0;
      end
      repeat (4) @(posedge i_clk);
      cmp32(n_good - g0, 32'd3);
      cmp32(n_bad - b0, 32'd0);
    end
    print_verdict();
  end
endmodule
